//--- adcs_defs.svh
// Constants for the converter sequencer: register map, field layout,
// reset values, data-rate and range tables, timing figures.
// Assumes it is included by bare name from each file that declares a module.
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADCS_ADDR_W 8
`define ADCS_OFS_CONFIG 8'h00
`define ADCS_OFS_RESULT 8'h04
`define ADCS_OFS_STATUS 8'h08
`define ADCS_OFS_LSB 8'h0c
`define ADCS_RESP_OKAY 2'h0
`define ADCS_RESP_SLVERR 2'h2

// ****************************************************************
// Configuration fields and reset values
// ****************************************************************
`define ADCS_CFG_MODE 0
`define ADCS_CFG_DR 3:1
`define ADCS_CFG_GAIN 6:4
`define ADCS_CFG_LANE0 0
`define ADCS_CFG_SEL 10:8
`define ADCS_CFG_START 15
`define ADCS_CFG_LANE1 1
`define ADCS_RST_MODE 1'b1
`define ADCS_RST_DR 3'h4
`define ADCS_RST_GAIN 3'h2
`define ADCS_RST_SEL 3'h0
`define ADCS_GAIN_FIXED 3'h2

// ****************************************************************
// Status fields
// ****************************************************************
`define ADCS_ST_BUSY 0
`define ADCS_ST_POWERED 1
`define ADCS_ST_NEW 2

// ****************************************************************
// Inputs, rates, ranges
// ****************************************************************
`define ADCS_ANALOG_INPUT_ZERO 2'h0
`define ADCS_ANALOG_INPUT_ONE 2'h1
`define ADCS_AIN2 2'h2
`define ADCS_ANALOG_INPUT_THREE 2'h3
`define ADCS_SPS_0 16'd8
`define ADCS_SPS_1 16'd16
`define ADCS_SPS_2 16'd32
`define ADCS_SPS_3 16'd64
`define ADCS_SPS_4 16'd128
`define ADCS_SPS_5 16'd250
`define ADCS_SPS_6 16'd475
`define ADCS_SPS_7 16'd860
`define ADCS_FSR_MV_0 64'd6144
`define ADCS_FSR_MV_1 64'd4096
`define ADCS_FSR_MV_2 64'd2048
`define ADCS_FSR_MV_3 64'd1024
`define ADCS_FSR_MV_4 64'd512
`define ADCS_FSR_MV_5 64'd256
`define ADCS_PV_PER_MV 64'd1000000000
`define ADCS_HALF_CODES 64'd32768
`define ADCS_CODE_W 16

// ****************************************************************
// Timing
// ****************************************************************
`define ADCS_CLK_HZ 250000000
`define ADCS_CLK_NS 4
`define ADCS_OSC_HZ 1000000
`define ADCS_MOD_DIV 4
`define ADCS_PWRUP_NS 25000

`endif

//--- adcs_host_model.sv
// Host model: an AXI4-Lite master with one write and one read task.
// Assumes one clock; the bench calls the tasks one at a time.
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_host_model (
  // Clock
  input wire logic i_clk,
  // Write channels
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [`ADCS_ADDR_W-1:0] o_awaddr,
  output logic o_wvalid,
  input wire logic i_wready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_bvalid,
  output logic o_bready,
  input wire logic [1:0] i_bresp,
  // Read channels
  output logic o_arvalid,
  input wire logic i_arready,
  output logic [`ADCS_ADDR_W-1:0] o_araddr,
  input wire logic i_rvalid,
  output logic o_rready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp
);
  // Handshakes are judged at the rising edge itself: every design output
  // is still the value it had before that edge, which is what the slave
  // sees as well.
  logic a_go, w_go, e_go;
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = '0;
    {o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clk);
    o_awvalid <= 1'b1;
    o_awaddr <= a;
    o_wvalid <= 1'b1;
    o_wdata <= d;
    o_wstrb <= 4'hf;
    o_bready <= 1'b1;
    e_go = 1'b0;
    while (!e_go) begin
      @(posedge i_clk);
      a_go = o_awvalid && i_awready;
      w_go = o_wvalid && i_wready;
      e_go = i_bvalid && o_bready;
      r = i_bresp;
      // Released address and data lines show the inverse, never the stale value.
      if (a_go) {o_awvalid, o_awaddr} <= {1'b0, ~a};
      if (w_go) {o_wvalid, o_wdata} <= {1'b0, ~d};
    end
    o_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clk);
    o_arvalid <= 1'b1;
    o_araddr <= a;
    o_rready <= 1'b1;
    e_go = 1'b0;
    while (!e_go) begin
      @(posedge i_clk);
      a_go = o_arvalid && i_arready;
      e_go = i_rvalid && o_rready;
      d = i_rdata;
      r = i_rresp;
      if (a_go) {o_arvalid, o_araddr} <= {1'b0, ~a};
    end
    o_rready <= 1'b0;
  endtask : rd
endmodule : adcs_host_model
`default_nettype wire

//--- adcs_pkg.sv
// Types shared by the converter sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package adcs_pkg;

  typedef enum logic [1:0] {
    ADCS_PWRDN = 2'b00,
    ADCS_WAKE = 2'b01,
    ADCS_CONV = 2'b11
  } adcs_state_t;

  typedef struct packed {
    logic [2:0] input_select_field;
    logic [2:0] gain_range_field;
    logic [2:0] data_rate_field;
    logic single_mode;
  } adcs_cfg_t;

  typedef struct packed {
    logic [2:0] gain_range_field;
    logic [1:0] pos_input;
    logic [1:0] neg_input;
    logic neg_to_gnd;
  } adcs_front_t;

endpackage : adcs_pkg

//--- adcs_rate_timer.sv
// Oscillator and sampling clock divider for the converter sequencer.
// Assumes the system clock is free running; the sampling clock only
// runs while the sequencer asks for it.
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"

module adcs_rate_timer #(
  parameter int OSC_DIV = `ADCS_CLK_HZ / `ADCS_OSC_HZ
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_run,
  // Sampling clock
  output logic o_mod_clk,
  output logic o_mod_tick
);

  localparam int OW = $clog2(OSC_DIV + 1);
  localparam int PW = $clog2(`ADCS_MOD_DIV);
  localparam logic [OW-1:0] OSC_LAST = OW'(OSC_DIV - 1);
  localparam logic [PW-1:0] PH_LAST = PW'(`ADCS_MOD_DIV - 1);
  localparam logic [PW-1:0] PH_HALF = PW'(`ADCS_MOD_DIV / 2);

  logic [OW-1:0] osc_cnt_reg;
  logic [PW-1:0] phase_reg;
  logic osc_tick;

  assign osc_tick = (osc_cnt_reg == OSC_LAST);

  // ****************************************************************
  // Internal oscillator rate
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_cnt_reg <= '0;
    end else if (osc_tick) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 1'b1;
    end
  end

  // ****************************************************************
  // Divide by four for the sampling clock
  // ****************************************************************
  // Phase restarts on every run so each conversion sees the same
  // alignment of sampling edges.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_reg <= '0;
    end else if (!i_run) begin
      phase_reg <= '0;
    end else if (osc_tick) begin
      phase_reg <= (phase_reg == PH_LAST) ? '0 : phase_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mod_tick <= 1'b0;
      o_mod_clk <= 1'b0;
    end else begin
      o_mod_tick <= i_run && osc_tick && (phase_reg == PH_LAST);
      o_mod_clk <= i_run && (phase_reg >= PH_HALF);
    end
  end

endmodule : adcs_rate_timer
`default_nettype wire

//--- adcs_rate_timer_end_marker_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- adcs_sequencer.sv
// Conversion sequencer of a 16-bit delta-sigma converter with an
// AXI4-Lite register slave.
// Assumes a digital filter that presents a signed, range-extended
// result on i_filt_data and restarts on o_filt_start.
//
// Summary of operation
// - Single-shot: one conversion, store, power down.
// - Continuous: restart at once after each conversion.
// - Continuous conversions complete at programmed data rate.
// - Result read anytime, always last complete one.
// - Input select picks four single or two pairs.
// - Input select also measures inputs zero, one against three.
// - Single-ended setting grounds negative converter input.
// - Sampling clock is oscillator divided by four.
// - Gain field picks six ranges, halving each below 4.096 V.
// - Code step weight is span over two to sixteen.
// - Variant without gain fixed at 2.048 V range.
// - Variant without multiplexer converts zero minus one.
// - Start bit wakes, clears, ignored while busy.
// - New settings apply from the next conversion.
// - Data rate picks eight rates, time is reciprocal.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"

module adcs_sequencer #(
  parameter bit HAS_MUX = 1'b1,
  parameter bit HAS_GAIN = 1'b1,
  parameter int FILT_W = 18,
  parameter int OSC_DIV = `ADCS_CLK_HZ / `ADCS_OSC_HZ,
  parameter int PWRUP_CYCLES =
    (`ADCS_PWRUP_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [`ADCS_ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [`ADCS_ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Converter front end
  input wire logic signed [FILT_W-1:0] i_filt_data,
  output var adcs_pkg::adcs_front_t o_front,
  output logic o_mod_clk,
  output logic o_powered,
  output logic o_filt_start
);
  import adcs_pkg::*;

  localparam int WW = $clog2(PWRUP_CYCLES + 1);
  localparam logic [WW-1:0] WAKE_LAST = WW'(PWRUP_CYCLES - 1);
  localparam int CW = `ADCS_CODE_W;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [15:0] conv_ticks(input logic [2:0] dr);
    logic [15:0] sps;
    sps = `ADCS_SPS_0;
    case (dr)
      3'h0: sps = `ADCS_SPS_0;
      3'h1: sps = `ADCS_SPS_1;
      3'h2: sps = `ADCS_SPS_2;
      3'h3: sps = `ADCS_SPS_3;
      3'h4: sps = `ADCS_SPS_4;
      3'h5: sps = `ADCS_SPS_5;
      3'h6: sps = `ADCS_SPS_6;
      default: sps = `ADCS_SPS_7;
    endcase
    return 16'((`ADCS_OSC_HZ / `ADCS_MOD_DIV) / int'(sps));
  endfunction : conv_ticks

  function automatic logic [31:0] lsb_pv(input logic [2:0] g);
    logic [63:0] mv;
    mv = `ADCS_FSR_MV_5;
    case (g)
      3'h0: mv = `ADCS_FSR_MV_0;
      3'h1: mv = `ADCS_FSR_MV_1;
      3'h2: mv = `ADCS_FSR_MV_2;
      3'h3: mv = `ADCS_FSR_MV_3;
      3'h4: mv = `ADCS_FSR_MV_4;
      default: mv = `ADCS_FSR_MV_5;
    endcase
    return 32'(mv * `ADCS_PV_PER_MV / `ADCS_HALF_CODES);
  endfunction : lsb_pv

  function automatic logic signed [CW-1:0] sat_code(
    input logic signed [FILT_W-1:0] x);
    logic [FILT_W-CW:0] top;
    top = x[FILT_W-1:CW-1];
    if (top == '0 || top == '1) begin
      return x[CW-1:0];
    end
    return x[FILT_W-1] ? {1'b1, {(CW-1){1'b0}}} : {1'b0, {(CW-1){1'b1}}};
  endfunction : sat_code

  function automatic adcs_front_t route(input adcs_cfg_t c);
    adcs_front_t f;
    f.gain_range_field = HAS_GAIN ? c.gain_range_field
                                  : `ADCS_GAIN_FIXED;
    f.pos_input = `ADCS_ANALOG_INPUT_ZERO;
    f.neg_input = `ADCS_ANALOG_INPUT_ONE;
    f.neg_to_gnd = 1'b0;
    if (HAS_MUX) begin
      case (c.input_select_field)
        3'h0: f.neg_input = `ADCS_ANALOG_INPUT_ONE;
        3'h1: f.neg_input = `ADCS_ANALOG_INPUT_THREE;
        3'h2: begin
          f.pos_input = `ADCS_ANALOG_INPUT_ONE;
          f.neg_input = `ADCS_ANALOG_INPUT_THREE;
        end
        3'h3: begin
          f.pos_input = `ADCS_AIN2;
          f.neg_input = `ADCS_ANALOG_INPUT_THREE;
        end
        default: begin
          f.pos_input = c.input_select_field[1:0];
          f.neg_input = `ADCS_ANALOG_INPUT_THREE;
          f.neg_to_gnd = 1'b1;
        end
      endcase
    end
    return f;
  endfunction : route

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic aw_held_reg, w_held_reg;
  logic [`ADCS_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire, rd_fire, wr_cfg, start_go, rd_result;
  adcs_state_t state_reg;
  adcs_cfg_t cfg_reg, act_reg;
  logic signed [CW-1:0] result_reg;
  logic new_reg;
  logic [31:0] rd_word;
  logic rd_ok;

  assign o_awready = !aw_held_reg;
  assign o_wready = !w_held_reg;
  assign o_arready = !o_rvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !o_bvalid;
  assign rd_fire = i_arvalid && !o_rvalid;
  assign wr_cfg = wr_fire && (awaddr_reg == `ADCS_OFS_CONFIG);
  assign start_go = wr_cfg && wstrb_reg[`ADCS_CFG_LANE1] &&
                    wdata_reg[`ADCS_CFG_START];
  assign rd_result = rd_fire && (i_araddr == `ADCS_OFS_RESULT);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (i_awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= i_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (i_wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg <= i_wdata;
      wstrb_reg <= i_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bvalid <= 1'b0;
      o_bresp <= `ADCS_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= (awaddr_reg == `ADCS_OFS_CONFIG) ? `ADCS_RESP_OKAY
                                                  : `ADCS_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Configuration changes at once; a running conversion keeps its own
  // copy in act_reg.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg.single_mode <= `ADCS_RST_MODE;
      cfg_reg.data_rate_field <= `ADCS_RST_DR;
      cfg_reg.gain_range_field <= `ADCS_RST_GAIN;
      cfg_reg.input_select_field <= `ADCS_RST_SEL;
    end else if (wr_cfg) begin
      if (wstrb_reg[`ADCS_CFG_LANE0]) begin
        cfg_reg.single_mode <= wdata_reg[`ADCS_CFG_MODE];
        cfg_reg.data_rate_field <= wdata_reg[`ADCS_CFG_DR];
        cfg_reg.gain_range_field <= wdata_reg[`ADCS_CFG_GAIN];
      end
      if (wstrb_reg[`ADCS_CFG_LANE1]) begin
        cfg_reg.input_select_field <= wdata_reg[`ADCS_CFG_SEL];
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (i_araddr)
      `ADCS_OFS_CONFIG: begin
        rd_word[`ADCS_CFG_MODE] = cfg_reg.single_mode;
        rd_word[`ADCS_CFG_DR] = cfg_reg.data_rate_field;
        rd_word[`ADCS_CFG_GAIN] = cfg_reg.gain_range_field;
        rd_word[`ADCS_CFG_SEL] = cfg_reg.input_select_field;
        rd_word[`ADCS_CFG_START] = (state_reg == ADCS_PWRDN);
      end
      `ADCS_OFS_RESULT: rd_word[CW-1:0] = result_reg;
      `ADCS_OFS_STATUS: begin
        rd_word[`ADCS_ST_BUSY] = (state_reg != ADCS_PWRDN);
        rd_word[`ADCS_ST_POWERED] = o_powered;
        rd_word[`ADCS_ST_NEW] = new_reg;
      end
      `ADCS_OFS_LSB: rd_word = lsb_pv(o_front.gain_range_field);
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= `ADCS_RESP_OKAY;
    end else if (rd_fire) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_ok ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Conversion sequence
  // ****************************************************************
  logic [WW-1:0] wake_cnt_reg;
  logic [15:0] conv_len_reg, conv_cnt_reg;
  logic mod_tick, conv_end;

  assign conv_end = (state_reg == ADCS_CONV) && mod_tick &&
                    (conv_cnt_reg == conv_len_reg - 1'b1);

  adcs_rate_timer #(
    .OSC_DIV(OSC_DIV)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_run(state_reg == ADCS_CONV),
    .o_mod_clk(o_mod_clk),
    .o_mod_tick(mod_tick)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ADCS_PWRDN;
      wake_cnt_reg <= '0;
      conv_cnt_reg <= '0;
      conv_len_reg <= '1;
      act_reg <= '0;
      o_filt_start <= 1'b0;
    end else begin
      o_filt_start <= 1'b0;
      case (state_reg)
        ADCS_PWRDN: begin
          wake_cnt_reg <= '0;
          if (start_go || !cfg_reg.single_mode) begin
            state_reg <= ADCS_WAKE;
          end
        end
        ADCS_WAKE: begin
          wake_cnt_reg <= wake_cnt_reg + 1'b1;
          if (wake_cnt_reg == WAKE_LAST) begin
            state_reg <= ADCS_CONV;
            act_reg <= cfg_reg;
            conv_len_reg <= conv_ticks(cfg_reg.data_rate_field);
            conv_cnt_reg <= '0;
            o_filt_start <= 1'b1;
          end
        end
        ADCS_CONV: begin
          if (conv_end) begin
            conv_cnt_reg <= '0;
            if (cfg_reg.single_mode) begin
              state_reg <= ADCS_PWRDN;
            end else begin
              act_reg <= cfg_reg;
              conv_len_reg <= conv_ticks(cfg_reg.data_rate_field);
              o_filt_start <= 1'b1;
            end
          end else if (mod_tick) begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
          end
        end
        default: state_reg <= ADCS_PWRDN;
      endcase
    end
  end

  // The result changes only in the cycle that ends a conversion, so a
  // read never sees a half-built value.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_reg <= '0;
    end else if (conv_end) begin
      result_reg <= sat_code(i_filt_data);
    end
  end

  // A finishing conversion wins over a result read in the same cycle.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      new_reg <= 1'b0;
    end else if (conv_end) begin
      new_reg <= 1'b1;
    end else if (rd_result) begin
      new_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_front <= '0;
      o_powered <= 1'b0;
    end else begin
      o_front <= route(act_reg);
      o_powered <= (state_reg != ADCS_PWRDN);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_start_taken;
    state_reg == ADCS_PWRDN && start_go;
  endsequence
  sequence s_woken;
    state_reg == ADCS_WAKE && wake_cnt_reg == '0;
  endsequence

  a_single_powerdown: assert property (conv_end && cfg_reg.single_mode
    |=> state_reg == ADCS_PWRDN ##1 !o_powered)
    else $error("single-shot did not power down");
  a_cont_restart: assert property (conv_end && !cfg_reg.single_mode
    |=> state_reg == ADCS_CONV && conv_cnt_reg == '0)
    else $error("continuous conversion did not restart");
  a_conv_length: assert property (state_reg == ADCS_CONV
    |-> conv_cnt_reg < conv_len_reg)
    else $error("conversion ran past its length");
  a_rate_reload: assert property (conv_end && !cfg_reg.single_mode
    |=> conv_len_reg == conv_ticks($past(cfg_reg.data_rate_field)))
    else $error("conversion length not set from data rate");
  a_result_hold: assert property (!conv_end |=> $stable(result_reg))
    else $error("result changed outside conversion end");
  a_result_sat: assert property (conv_end
    |=> result_reg == sat_code($past(i_filt_data)))
    else $error("result not the saturated filter value");
  a_gnd_switch: assert property (o_powered |-> o_front.neg_to_gnd ==
    (HAS_MUX && $past(act_reg.input_select_field[2])))
    else $error("ground switch does not follow input select");
  a_fixed_pair: assert property (!HAS_MUX |-> o_front.pos_input ==
    `ADCS_ANALOG_INPUT_ZERO && o_front.neg_input == `ADCS_ANALOG_INPUT_ONE)
    else $error("fixed input pair violated");
  a_fixed_gain: assert property (!HAS_GAIN
    |-> o_front.gain_range_field == `ADCS_GAIN_FIXED)
    else $error("fixed range violated");
  a_start_wake: assert property (s_start_taken |=> s_woken)
    else $error("start bit did not begin wake-up");
  a_start_ignored: assert property (state_reg == ADCS_CONV && start_go
    && !conv_end |=> state_reg == ADCS_CONV)
    else $error("start accepted while converting");
  a_wake_bound: assert property (state_reg == ADCS_WAKE
    |-> wake_cnt_reg <= WAKE_LAST)
    else $error("wake-up longer than power-up time");
  a_settings_held: assert property (state_reg == ADCS_CONV && !conv_end
    |=> $stable(act_reg))
    else $error("settings changed mid conversion");

endmodule : adcs_sequencer
`default_nettype wire

//--- adcs_sequencer_tb_top.sv
// Bench for the conversion sequencer: host model, random filter data.
// Assumes the sequencer and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_sequencer_tb_top;
  import adcs_pkg::*;
  localparam int OD = 2;
  localparam int TCONV = 290 * 4 * OD;
  logic i_clk, i_rst_b, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic mclk, pwr, fst, mc_q;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] bre, rre;
  logic signed [17:0] filt;
  adcs_front_t front;
  int n_mismatch, check_count, seed, cyc, n_st, t_last, t_prev, n_mc;
  adcs_sequencer #(.OSC_DIV(OD), .PWRUP_CYCLES(8)) u_adcs_sequencer (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
    .i_wstrb(ws), .o_bvalid(bv), .i_bready(br), .o_bresp(bre),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
    .i_rready(rr), .o_rdata(rdat), .o_rresp(rre), .i_filt_data(filt),
    .o_front(front), .o_mod_clk(mclk), .o_powered(pwr),
    .o_filt_start(fst));
  adcs_host_model u_adcs_host_model (
    .i_clk(i_clk), .o_awvalid(awv), .i_awready(awr), .o_awaddr(awa),
    .o_wvalid(wv), .i_wready(wrd), .o_wdata(wd), .o_wstrb(ws),
    .i_bvalid(bv), .o_bready(br), .i_bresp(bre), .o_arvalid(arv),
    .i_arready(arr), .o_araddr(ara), .i_rvalid(rv), .o_rready(rr),
    .i_rdata(rdat), .i_rresp(rre));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    mc_q <= mclk;
    if (mclk === 1'b1 && mc_q === 1'b0) n_mc <= n_mc + 1;
    if (fst === 1'b1) begin
      n_st <= n_st + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
  function automatic int sat(input int v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction : sat
  function automatic logic [7:0] fr(input int s, input int g);
    int p, n;
    p = s >= 4 ? s - 4 : (s == 0 ? 0 : s - 1);
    n = s == 0 ? 1 : 3;
    return {g[2:0], p[1:0], n[1:0], s >= 4};
  endfunction : fr
  function automatic longint lsb(input int g);
    longint mv[6] = '{6144, 4096, 2048, 1024, 512, 256};
    return mv[g] * 64'd1000000000 / 32768;
  endfunction : lsb
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_adcs_host_model.rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", er, r);
  endtask : rchk
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    logic [1:0] r;
    u_adcs_host_model.wr(a, d, r);
    chk("bresp", er, r);
  endtask : wchk
  task automatic wait_st(input int n);
    for (int k = 0; k < 9000 && n_st < n; k++) @(posedge i_clk);
  endtask : wait_st
  task automatic wait_pwr(input logic lv);
    for (int k = 0; k < 9000 && pwr !== lv; k++) @(posedge i_clk);
    chk("powered", lv, pwr);
  endtask : wait_pwr
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    int g, v, n0, m0, cfg;
    {i_rst_b, filt, cyc, n_st, t_last, t_prev, n_mc, mc_q} = '0;
    {n_mismatch, check_count} = '0;
    seed = 32'hb3a1;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    chk("pwr_rst", 0, pwr);
    rchk("cfg_rst", `ADCS_OFS_CONFIG, 32'h8029, `ADCS_RESP_OKAY);
    rchk("unmapped", 8'h10, 0, `ADCS_RESP_SLVERR);
    wchk(`ADCS_OFS_RESULT, 32'h1234, `ADCS_RESP_SLVERR);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      g = s % 6;
      v = $random(seed) % 131072;
      filt <= v[17:0];
      cfg = 1 | (7 << 1) | (g << 4) | (s << 8) | (1 << 15);
      n0 = n_st;
      m0 = n_mc;
      wchk(`ADCS_OFS_CONFIG, cfg, `ADCS_RESP_OKAY);
      wait_pwr(1'b1);
      repeat (20) @(posedge i_clk);
      chk("front", fr(s, g), front);
      wchk(`ADCS_OFS_CONFIG, cfg, `ADCS_RESP_OKAY);
      wait_pwr(1'b0);
      chk("starts", n0 + 1, n_st);
      chk("modclk", 1, n_mc - m0 inside {[289:291]});
      rchk("status", `ADCS_OFS_STATUS, 4, `ADCS_RESP_OKAY);
      rchk("result", `ADCS_OFS_RESULT, sat(v) & 32'hffff,
           `ADCS_RESP_OKAY);
      rchk("lsb", `ADCS_OFS_LSB, lsb(g), `ADCS_RESP_OKAY);
      rchk("new_clr", `ADCS_OFS_STATUS, 0, `ADCS_RESP_OKAY);
    end
    $display("test single done");
    n0 = n_st;
    wchk(`ADCS_OFS_CONFIG, 32'h002e, `ADCS_RESP_OKAY);
    wait_st(n0 + 2);
    wchk(`ADCS_OFS_CONFIG, 32'h032e, `ADCS_RESP_OKAY);
    chk("front_old", fr(0, 2), front);
    wait_st(n0 + 3);
    repeat (3) @(posedge i_clk);
    chk("period", 1, t_last - t_prev inside {[TCONV-4:TCONV+4]});
    chk("front_new", fr(3, 2), front);
    wchk(`ADCS_OFS_CONFIG, 32'h032f, `ADCS_RESP_OKAY);
    wait_pwr(1'b0);
    chk("last_starts", n0 + 3, n_st);
    $display("test continuous done");
    print_verdict();
  end
endmodule : adcs_sequencer_tb_top
`default_nettype wire
